// *** hw/irqrt_regs.svh ***
// register offsets, field positions and reset values of the interrupt and pin routing bank
// assumes byte addressing on a 32-bit word register port
`ifndef IRQRT_REGS_SVH
`define IRQRT_REGS_SVH

`define IRQRT_ADDR_W          8
`define IRQRT_OFF_FLAG        8'h38
`define IRQRT_OFF_FLAG_CLEAR  8'h3C
`define IRQRT_OFF_ENABLE      8'h40
`define IRQRT_OFF_PIN_EN      8'h44
`define IRQRT_OFF_PIN_LOC     8'h48
`define IRQRT_OFF_CTRL        8'h4C
`define IRQRT_NUM_EVENTS      19
`define IRQRT_FLAG_VALID      19'h7FFCF
`define IRQRT_ENABLE_VALID    19'h7FFFF
`define IRQRT_RESET_FLAGS     19'h00010
`define IRQRT_RESET_ENABLE    19'h00000
`define IRQRT_BIT_TXC         3
`define IRQRT_BIT_ADDR        2
`define IRQRT_BIT_REPEATED_START_SEEN      1
`define IRQRT_BIT_START       0
`define IRQRT_BIT_CLK_PEN     1
`define IRQRT_BIT_DATA_PEN    0
`define IRQRT_CLK_LOC_LSB     8
`define IRQRT_DATA_LOC_LSB    0
`define IRQRT_LOC_W           6
`define IRQRT_NUM_LOCS        32
`define IRQRT_BIT_RD_CLEAR    0

`endif

// *** hw/irqrt_pkg.sv ***
// types shared by the interrupt and pin routing bank
// assumes the register header is on the include path
package irqrt_pkg;
   typedef logic [18:0] irqrt_vec_t;
   typedef logic [5:0]  irqrt_loc_t;
   typedef logic [31:0] irqrt_word_t;
endpackage

// *** hw/irqrt_pin_mux.sv ***
// routes one open-drain controller line to one of a number of pin positions
// assumes pin inputs are already synchronised by the caller
`timescale 1ns/1ps
module irqrt_pin_mux #(
   parameter int NUM_LOCS = 32
) (
   input  wire logic                      en_i,
   input  wire irqrt_pkg::irqrt_loc_t     loc_i,
   input  wire logic                      line_oe_i,
   input  wire logic [NUM_LOCS-1:0]       pin_in_i,
   output logic      [NUM_LOCS-1:0]       pin_oe_o,
   output logic                           line_in_o
);
   import irqrt_pkg::*;

   // one pulling driver per location, only the selected one active
   genvar g;
   generate
      for (g = 0; g < NUM_LOCS; g++) begin : g_loc
         assign pin_oe_o[g] = en_i && line_oe_i && (loc_i == irqrt_loc_t'(g));
      end
   endgenerate

   // selected pin seen by controller; idles high when detached or out of range
   always_comb begin
      line_in_o = 1'b1;
      if (en_i && (loc_i < irqrt_loc_t'(NUM_LOCS))) begin
         line_in_o = pin_in_i[loc_i[4:0]];
      end
   end
endmodule

// *** hw/irqrt_bank.sv ***
// interrupt flag, enable and pin routing register bank of a two-wire controller
// assumes a single clock, synchronous reset and a one-cycle register port
// Summary of operation
// [R1] write one clears flags 18..6 and 3..0, zero ignored
// [R2] read-clear mode: read returns flags, clears them
// [R3] nineteen enable bits, reset zero, read-write
// [R4] clock pin enable bit connects clock line
// [R5] data pin enable bit connects data line
// [R6] location fields route each line to pin
// [R7] software writes zero to reserved bits
// [R8] interrupt high when enabled flag set
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "irqrt_regs.svh"
module irqrt_bank #(
   parameter int NUM_LOCS = `IRQRT_NUM_LOCS
) (
   input  wire logic                           SYS_CLK_I,
   input  wire logic                           RST_I,
   input  wire logic [`IRQRT_ADDR_W-1:0]       ADDR_I,
   input  wire irqrt_pkg::irqrt_word_t         WDATA_I,
   input  wire logic                           WR_I,
   input  wire logic                           RD_I,
   output irqrt_pkg::irqrt_word_t              RDATA_O,
   input  wire irqrt_pkg::irqrt_vec_t          EVENT_SET_I,
   output logic                                IRQ_O,
   output irqrt_pkg::irqrt_vec_t               FLAGS_O,
   input  wire logic                           CLK_LINE_OE_I,
   input  wire logic                           DATA_LINE_OE_I,
   output logic                                CLK_LINE_IN_O,
   output logic                                DATA_LINE_IN_O,
   input  wire logic [NUM_LOCS-1:0]            CLK_PIN_I,
   input  wire logic [NUM_LOCS-1:0]            DATA_PIN_I,
   output logic      [NUM_LOCS-1:0]            CLK_PIN_O,
   output logic      [NUM_LOCS-1:0]            CLK_PIN_OE_O,
   output logic      [NUM_LOCS-1:0]            DATA_PIN_O,
   output logic      [NUM_LOCS-1:0]            DATA_PIN_OE_O
);
   import irqrt_pkg::*;

   typedef struct packed {
      irqrt_vec_t          flags;
      irqrt_vec_t          enable;
      logic                clk_pen;
      logic                data_pen;
      irqrt_loc_t          clk_loc;
      irqrt_loc_t          data_loc;
      logic                rd_clear;
      irqrt_word_t         rdata;
      logic [NUM_LOCS-1:0] clk_s1;
      logic [NUM_LOCS-1:0] clk_s2;
      logic [NUM_LOCS-1:0] clk_s3;
      logic [NUM_LOCS-1:0] data_s1;
      logic [NUM_LOCS-1:0] data_s2;
      logic [NUM_LOCS-1:0] data_s3;
      logic [NUM_LOCS-1:0] clk_clean;
      logic [NUM_LOCS-1:0] data_clean;
   } irqrt_state_t;

   irqrt_state_t st_r;
   irqrt_state_t st_nxt;

   // register address match used by both read and write paths
   function automatic logic hit(input logic [`IRQRT_ADDR_W-1:0] a,
                                input logic [`IRQRT_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   // next state: bus access, flag set and clear, pin synchronisers
   always_comb begin
      irqrt_vec_t clr;
      irqrt_vec_t cur;
      clr    = '0;
      cur    = st_r.flags & irqrt_vec_t'(`IRQRT_FLAG_VALID);
      st_nxt = st_r;
      // read data exist only in the cycle after the read strobe
      st_nxt.rdata = '0;
      if (RD_I) begin
         if (hit(ADDR_I, `IRQRT_OFF_FLAG)) begin
            st_nxt.rdata = irqrt_word_t'(cur);
         end else if (hit(ADDR_I, `IRQRT_OFF_FLAG_CLEAR)) begin
            if (st_r.rd_clear) begin
               st_nxt.rdata = irqrt_word_t'(cur); // [R2]
               clr          = cur;                // [R2]
            end
         end else if (hit(ADDR_I, `IRQRT_OFF_ENABLE)) begin
            st_nxt.rdata = irqrt_word_t'(st_r.enable);
         end else if (hit(ADDR_I, `IRQRT_OFF_PIN_EN)) begin
            st_nxt.rdata[`IRQRT_BIT_CLK_PEN]  = st_r.clk_pen;
            st_nxt.rdata[`IRQRT_BIT_DATA_PEN] = st_r.data_pen;
         end else if (hit(ADDR_I, `IRQRT_OFF_PIN_LOC)) begin
            st_nxt.rdata[`IRQRT_CLK_LOC_LSB +: `IRQRT_LOC_W]  = st_r.clk_loc;
            st_nxt.rdata[`IRQRT_DATA_LOC_LSB +: `IRQRT_LOC_W] = st_r.data_loc;
         end else if (hit(ADDR_I, `IRQRT_OFF_CTRL)) begin
            st_nxt.rdata[`IRQRT_BIT_RD_CLEAR] = st_r.rd_clear;
         end
      end
      // writes; reserved bits are dropped, software keeps them zero [R7]
      if (WR_I) begin
         if (hit(ADDR_I, `IRQRT_OFF_FLAG_CLEAR)) begin
            // ones clear flags, zeros leave them alone [R1]
            clr = clr | (WDATA_I[18:0] & irqrt_vec_t'(`IRQRT_FLAG_VALID));
         end else if (hit(ADDR_I, `IRQRT_OFF_ENABLE)) begin
            st_nxt.enable = WDATA_I[18:0] & irqrt_vec_t'(`IRQRT_ENABLE_VALID); // [R3]
         end else if (hit(ADDR_I, `IRQRT_OFF_PIN_EN)) begin
            st_nxt.clk_pen  = WDATA_I[`IRQRT_BIT_CLK_PEN];  // [R4]
            st_nxt.data_pen = WDATA_I[`IRQRT_BIT_DATA_PEN]; // [R5]
         end else if (hit(ADDR_I, `IRQRT_OFF_PIN_LOC)) begin
            st_nxt.clk_loc  = WDATA_I[`IRQRT_CLK_LOC_LSB +: `IRQRT_LOC_W];  // [R6]
            st_nxt.data_loc = WDATA_I[`IRQRT_DATA_LOC_LSB +: `IRQRT_LOC_W]; // [R6]
         end else if (hit(ADDR_I, `IRQRT_OFF_CTRL)) begin
            st_nxt.rd_clear = WDATA_I[`IRQRT_BIT_RD_CLEAR];
         end
      end
      // a new event beats a simultaneous clear
      st_nxt.flags = ((cur & ~clr) | EVENT_SET_I) & irqrt_vec_t'(`IRQRT_FLAG_VALID);
      // three-stage synchronisers; level taken once stages two and three agree
      st_nxt.clk_s1  = CLK_PIN_I;
      st_nxt.clk_s2  = st_r.clk_s1;
      st_nxt.clk_s3  = st_r.clk_s2;
      st_nxt.data_s1 = DATA_PIN_I;
      st_nxt.data_s2 = st_r.data_s1;
      st_nxt.data_s3 = st_r.data_s2;
      for (int i = 0; i < NUM_LOCS; i++) begin
         if (st_r.clk_s2[i] == st_r.clk_s3[i]) begin
            st_nxt.clk_clean[i] = st_r.clk_s3[i];
         end
         if (st_r.data_s2[i] == st_r.data_s3[i]) begin
            st_nxt.data_clean[i] = st_r.data_s3[i];
         end
      end
   end

   // state register, bus-idle pins read high after reset
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         st_r            <= '0;
         // unstored flag positions are masked so the flags do not drop a cycle after reset
         st_r.flags      <= irqrt_vec_t'(`IRQRT_RESET_FLAGS) & irqrt_vec_t'(`IRQRT_FLAG_VALID);
         st_r.enable     <= irqrt_vec_t'(`IRQRT_RESET_ENABLE);
         st_r.clk_s1     <= '1;
         st_r.clk_s2     <= '1;
         st_r.clk_s3     <= '1;
         st_r.data_s1    <= '1;
         st_r.data_s2    <= '1;
         st_r.data_s3    <= '1;
         st_r.clk_clean  <= '1;
         st_r.data_clean <= '1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs
   assign RDATA_O = st_r.rdata;
   assign FLAGS_O = st_r.flags;
   assign IRQ_O   = |(st_r.flags & st_r.enable); // [R8]
   assign CLK_PIN_O  = '0;
   assign DATA_PIN_O = '0;

   // clock line routing [R4] [R6]
   irqrt_pin_mux #(
      .NUM_LOCS (NUM_LOCS)
   ) u_clk_mux (
      .en_i      (st_r.clk_pen),
      .loc_i     (st_r.clk_loc),
      .line_oe_i (CLK_LINE_OE_I),
      .pin_in_i  (st_r.clk_clean),
      .pin_oe_o  (CLK_PIN_OE_O),
      .line_in_o (CLK_LINE_IN_O)
   );

   // data line routing [R5] [R6]
   irqrt_pin_mux #(
      .NUM_LOCS (NUM_LOCS)
   ) u_data_mux (
      .en_i      (st_r.data_pen),
      .loc_i     (st_r.data_loc),
      .line_oe_i (DATA_LINE_OE_I),
      .pin_in_i  (st_r.data_clean),
      .pin_oe_o  (DATA_PIN_OE_O),
      .line_in_o (DATA_LINE_IN_O)
   );
endmodule

// *** tb/irqrt_bank_props.sv ***
// port checker for the interrupt and pin routing bank
// assumes it is bound into irqrt_bank, one clock, sync reset
`timescale 1ns/1ps
module irqrt_bank_props #(
   parameter int NUM_LOCS = 32
) (
   input wire logic                  SYS_CLK_I,
   input wire logic                  RST_I,
   input wire logic [7:0]            ADDR_I,
   input wire irqrt_pkg::irqrt_word_t WDATA_I,
   input wire logic                  WR_I,
   input wire logic                  RD_I,
   input wire irqrt_pkg::irqrt_word_t RDATA_O,
   input wire irqrt_pkg::irqrt_vec_t EVENT_SET_I,
   input wire logic                  IRQ_O,
   input wire irqrt_pkg::irqrt_vec_t FLAGS_O,
   input wire logic                  CLK_LINE_OE_I,
   input wire logic                  DATA_LINE_OE_I,
   input wire logic [NUM_LOCS-1:0]   CLK_PIN_OE_O,
   input wire logic [NUM_LOCS-1:0]   DATA_PIN_OE_O
);
   import irqrt_pkg::*;
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);
   // register port requests
   sequence s_rd(logic [7:0] a);
      RD_I && ADDR_I == a;
   endsequence
   sequence s_clr(int b);
      WR_I && ADDR_I == 8'h3C && WDATA_I[b];
   endsequence
   a_w1_clears: assert property (s_clr(3) ##0 !EVENT_SET_I[3] |=> !FLAGS_O[3])
      else $error("flag 3 not cleared by write one");
   a_zero_keeps: assert property (WR_I && ADDR_I == 8'h3C && !WDATA_I[0] && FLAGS_O[0]
      |=> FLAGS_O[0]) else $error("flag 0 lost on zero write");
   a_event_sets: assert property (EVENT_SET_I[2] |=> FLAGS_O[2])
      else $error("flag 2 not set by event");
   a_rdclr_clears: assert property (s_rd(8'h3C) |=> ((FLAGS_O & RDATA_O[18:0]) & 19'h7FFCF)
      == ($past(EVENT_SET_I) & RDATA_O[18:0] & 19'h7FFCF)) else $error("read clear");
   a_enable_resv: assert property (s_rd(8'h40) |=> RDATA_O[31:19] == 13'h0)
      else $error("enable reserved bits set");
   a_rd_quiet: assert property (!RD_I |=> RDATA_O == 32'h0)
      else $error("read data outside read cycle");
   a_clk_route: assert property (CLK_PIN_OE_O != '0 |-> CLK_LINE_OE_I && $onehot(CLK_PIN_OE_O))
      else $error("clock pin drive wrong");
   a_data_route: assert property (DATA_PIN_OE_O != '0 |-> DATA_LINE_OE_I && $onehot(DATA_PIN_OE_O))
      else $error("data pin drive wrong");
   a_loc_resv: assert property (s_rd(8'h48) |=> RDATA_O[31:14] == 18'h0 && RDATA_O[7:6] == 2'h0)
      else $error("location reserved bits set");
   a_irq_flag: assert property (IRQ_O |-> FLAGS_O != '0)
      else $error("interrupt without flag");
endmodule
bind irqrt_bank irqrt_bank_props #(.NUM_LOCS(NUM_LOCS)) u_props (.SYS_CLK_I(SYS_CLK_I),
   .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
   .RDATA_O(RDATA_O), .EVENT_SET_I(EVENT_SET_I), .IRQ_O(IRQ_O), .FLAGS_O(FLAGS_O),
   .CLK_LINE_OE_I(CLK_LINE_OE_I), .DATA_LINE_OE_I(DATA_LINE_OE_I),
   .CLK_PIN_OE_O(CLK_PIN_OE_O), .DATA_PIN_OE_O(DATA_PIN_OE_O));

// *** tb/irqrt_bank_tb_top.sv ***
// self-checking bench for the interrupt and pin routing bank
// assumes the design files and irqrt_bank_props are compiled first
`timescale 1ns/1ps
module irqrt_bank_tb_top;
   import irqrt_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, cloe = 0, dloe = 0, irq, cin, din;
   logic [7:0] addr = '0;
   irqrt_word_t wdata = '0, rdata, v;
   irqrt_vec_t ev_r = '0, flags;
   logic [31:0] dpin = '1, cpo, cpoe, dpo, dpoe;
   int err_count = 0, samples_checked = 0, cyc = 0;
   // rows: write flag, address, write data, read back
   logic       rw [9] = '{0, 0, 0, 0, 1, 1, 1, 1, 1};
   logic [7:0] ra [9] = '{8'h38, 8'h40, 8'h44, 8'h48, 8'h40, 8'h44, 8'h48, 8'h50, 8'h40};
   logic [31:0] rd_v [9] = '{0, 0, 0, 0, 32'h7FFFF, 32'h3, 32'h1F05, 32'h5, 0};
   logic [31:0] re [9] = '{0, 0, 0, 0, 32'h7FFFF, 32'h3, 32'h1F05, 0, 0};
   irqrt_bank uut (.SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdata), .EVENT_SET_I(ev_r), .IRQ_O(irq), .FLAGS_O(flags),
      .CLK_LINE_OE_I(cloe), .DATA_LINE_OE_I(dloe), .CLK_LINE_IN_O(cin), .DATA_LINE_IN_O(din),
      .CLK_PIN_I(32'hFFFFFFFF), .DATA_PIN_I(dpin), .CLK_PIN_O(cpo), .CLK_PIN_OE_O(cpoe),
      .DATA_PIN_O(dpo), .DATA_PIN_OE_O(dpoe));
   // clock and hang guard
   initial begin
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         final_report();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // reserved bits are always written as zero
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge clk) wr <= 0;
      #1;
   endtask
   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk) {rd, addr} <= {1'b1, a};
      @(posedge clk) rd <= 0;
      #1 d = rdata;
   endtask
   task automatic ev(input irqrt_vec_t e);
      @(posedge clk) ev_r <= e;
      @(posedge clk) ev_r <= '0;
      #1;
   endtask
   function automatic logic [31:0] fm();
      return {13'h0, flags & 19'h7FFCF};
   endfunction
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 0;
      for (int i = 0; i < 9; i++) begin
         if (rw[i]) bus_wr(ra[i], rd_v[i]);
         bus_rd(ra[i], v);
         chk("register", re[i], v);
      end
      // routing: clock to location 31, data to location 5
      @(posedge clk) {cloe, dloe, dpin} <= {2'b11, 32'hFFFFFFDF};
      repeat (6) @(posedge clk);
      #1 chk("clk oe", 32'h80000000, cpoe);
      chk("clk in", 1, cin);
      chk("pin out", 0, cpo | dpo);
      chk("data oe", 32'h20, dpoe);
      chk("data in", 0, din);
      bus_wr(8'h44, 32'h2);
      chk("data off", 0, {dpoe[31:1], ~din});
      bus_wr(8'h44, 32'h0);
      chk("clk off", 0, cpoe);
      ev(19'h7FFCF);
      bus_wr(8'h3C, 32'h5);
      chk("flags", 32'h7FFCA, fm());
      bus_wr(8'h3C, 32'h0);
      chk("flags", 32'h7FFCA, fm());
      chk("irq", 0, irq);
      bus_wr(8'h40, 32'h40);
      chk("irq", 1, irq);
      bus_wr(8'h3C, 32'h7FFCA);
      chk("flags", 0, {12'h0, flags & 19'h7FFCF, irq});
      bus_wr(8'h4C, 32'h1);
      ev(19'h00108);
      bus_rd(8'h3C, v);
      chk("rdclr", 32'h108, v & 32'h7FFCF);
      chk("flags", 0, fm());
      // mid-run reset with an enabled flag pending
      ev(19'h00040);
      chk("irq", 1, irq);
      @(posedge clk) rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      #1 chk("irq rst", 0, irq);
      chk("flags rst", 0, fm());
      chk("rdata rst", 0, rdata);
      bus_rd(8'h40, v);
      chk("enable rst", 0, v);
      bus_rd(8'h48, v);
      chk("loc rst", 0, v);
      chk("oe rst", 0, cpoe | dpoe);
      final_report();
   end
endmodule
